//--- design/adcrb_map.vh
// address map, field positions, reset values and timing counts of the converter register bank
`ifndef ADCRB_MAP_VH
`define ADCRB_MAP_VH

// register indexes; byte address on the bus is four times the index
`define ADCRB_IDX_CONTROL_PRIMARY 6'h00
`define ADCRB_IDX_REFERENCE_CONTROL 6'h01
`define ADCRB_IDX_AVERAGING_CONTROL 6'h02
`define ADCRB_IDX_SAMPLE_TIME_CONTROL 6'h03
`define ADCRB_IDX_CONTROL_SECONDARY 6'h04
`define ADCRB_IDX_WINDOW_CONTROL 6'h08
`define ADCRB_IDX_SOFTWARE_TRIGGER 6'h0C
`define ADCRB_IDX_INPUT_SELECT_CONTROL 6'h10
`define ADCRB_IDX_EVENT_CONTROL 6'h14
`define ADCRB_IDX_IRQ_ENABLE_CLEAR 6'h16
`define ADCRB_IDX_IRQ_ENABLE_SET 6'h17
`define ADCRB_IDX_IRQ_FLAGS 6'h18
`define ADCRB_IDX_SYNC_STATUS 6'h19
`define ADCRB_IDX_CONVERSION_RESULT 6'h1A
`define ADCRB_IDX_WINDOW_LOWER_THRESHOLD 6'h1C
`define ADCRB_IDX_WINDOW_UPPER_THRESHOLD 6'h20
`define ADCRB_IDX_GAIN_CORRECTION 6'h24
`define ADCRB_IDX_OFFSET_CORRECTION 6'h26
`define ADCRB_IDX_CALIBRATION_VALUES 6'h28
`define ADCRB_IDX_DEBUG_HOLD_CONTROL 6'h2A

// control_primary fields
`define ADCRB_BIT_SOFT_RESET 0
`define ADCRB_BIT_ENABLE 1
`define ADCRB_BIT_STANDBY_RUN 2
// sync_status field
`define ADCRB_BIT_SYNC_PENDING 7
// software_trigger fields
`define ADCRB_BIT_FLUSH 0
`define ADCRB_BIT_START 1
// irq_flags / irq enable fields
`define ADCRB_IRQ_RESRDY 0
`define ADCRB_IRQ_OVERRUN 1
`define ADCRB_IRQ_WINMON 2
`define ADCRB_IRQ_SYNCRDY 3
`define ADCRB_IRQ_W 4

// plain read/write registers, entry i sits at slice i
`define ADCRB_RW_COUNT 13
`define ADCRB_RW_IDX {6'h2A, 6'h28, 6'h26, 6'h24, 6'h20, 6'h1C, 6'h14, 6'h10, 6'h08, 6'h04, \
  6'h03, 6'h02, 6'h01}
`define ADCRB_RW_MASK {32'h0000_0001, 32'h0000_07FF, 32'h0000_0FFF, 32'h0000_0FFF, \
  32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_0033, 32'h0FFF_1F1F, 32'h0000_0007, \
  32'h0000_073F, 32'h0000_003F, 32'h0000_007F, 32'h0000_008F}
`define ADCRB_RW_WPROT 13'h1FFF
`define ADCRB_RW_EPROT 13'h000F
`define ADCRB_RW_WSYNC 13'h01B8
`define ADCRB_RW_SRST 13'h0FFF
`define ADCRB_RESET_VALUE 32'h0000_0000

// converter-domain rate: peripheral clock divided by 4, handshake spans 3 converter ticks
`define ADCRB_CONV_DIV 3'd4
`define ADCRB_SYNC_TICKS 2'd3

`endif

//--- design/adcrb_field_reg.v
// one read/write register with byte-lane writes, a fixed implemented-bit mask and soft clear
`timescale 1ns/100ps
`include "adcrb_map.vh"

module adcrb_field_reg #(
  parameter [31:0] WMASK = 32'hFFFF_FFFF,
  parameter SOFT_CLEARABLE = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire soft_clear,
  input wire wr_en,
  input wire [3:0] wstrb,
  input wire [31:0] wdata,
  output reg [31:0] q
);
  wire [31:0] lane_mask;
  wire [31:0] mask;

  assign lane_mask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  assign mask = lane_mask & WMASK;

  always @(posedge aclk) begin
    if (!aresetn) begin
      q <= `ADCRB_RESET_VALUE;
    end else if (soft_clear && (SOFT_CLEARABLE != 0)) begin
      q <= `ADCRB_RESET_VALUE;
    end else if (wr_en) begin
      q <= (q & ~mask) | (wdata & mask);
    end
  end
endmodule // adcrb_field_reg

//--- design/adcrb_sync_engine.v
// converter-domain handshake timer driven by a divided clock enable
`timescale 1ns/100ps
`include "adcrb_map.vh"

module adcrb_sync_engine (
  input wire aclk,
  input wire aresetn,
  input wire start,
  output reg busy,
  output reg done
);
  reg [2:0] div_cnt;
  reg [1:0] tick_cnt;
  wire conv_tick;

  assign conv_tick = (div_cnt == `ADCRB_CONV_DIV - 3'd1);

  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      div_cnt <= 3'd0;
      tick_cnt <= 2'd0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        div_cnt <= 3'd0;
        tick_cnt <= 2'd0;
      end else if (busy) begin
        if (conv_tick) begin
          div_cnt <= 3'd0;
          if (tick_cnt == `ADCRB_SYNC_TICKS - 2'd1) begin
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            tick_cnt <= tick_cnt + 2'd1;
          end
        end else begin
          div_cnt <= div_cnt + 3'd1;
        end
      end
    end
  end
endmodule // adcrb_sync_engine

//--- design/adcrb_top.v
// converter register bank: AXI4-Lite slave, control_primary logic and synchronised access
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "adcrb_map.vh"

// What this block does
// - accepts 8, 16 or 32 bit accesses matching each register's width.
// - each byte lane and 16-bit half is separately readable and writable.
// - write-protected registers ignore writes while the write guard is asserted.
// - enable-protected registers change only while the converter is disabled.
// - standby_run set keeps converter running in standby; clear halts it.
// - enable write reads back at once and raises sync_pending until applied.
// - writing zero to soft_reset_bit does nothing.
// - soft reset clears all registers except debug_hold_control, leaves in irq_flags only the flags raised with it (SYNCRDY always) and disables converter.
// - a write setting soft_reset_bit discards the other written fields.
// - soft_reset_bit reads one until reset completes; then it and sync_pending clear.
// - synchronised register writes start the cross-domain handshake; only software_trigger and input select reads wait for it.
// - a synchronised access during sync_pending stalls the bus, then completes.
// - writing one to an irq_flags bit clears it; zero leaves it.
module adcrb_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire peripheral_write_guard,
  input wire standby_sleep,
  input wire [15:0] conv_result,
  input wire ev_resrdy,
  input wire ev_overrun,
  input wire ev_winmon,
  output reg adc_enabled,
  output reg adc_run,
  output reg sw_start,
  output reg sw_flush
);
  localparam RD_IDLE = 3'd0;
  localparam RD_WAIT = 3'd1;
  localparam RD_SYNC = 3'd2;
  localparam RD_DATA = 3'd3;
  localparam RD_HOLD = 3'd4;
  localparam N = `ADCRB_RW_COUNT;
  localparam [N*6-1:0] RW_IDX = `ADCRB_RW_IDX;
  localparam [N*32-1:0] RW_MASK = `ADCRB_RW_MASK;
  localparam [N-1:0] RW_WPROT = `ADCRB_RW_WPROT;
  localparam [N-1:0] RW_EPROT = `ADCRB_RW_EPROT;
  localparam [N-1:0] RW_WSYNC = `ADCRB_RW_WSYNC;
  localparam [N-1:0] RW_SRST = `ADCRB_RW_SRST;
  localparam [1:0] RESP_OKAY = 2'b00;

  // control_primary
  reg soft_reset_bit;
  reg ctrl_enable;
  reg standby_run;
  // software_trigger pending bits, applied at handshake end
  reg trig_start;
  reg trig_flush;
  reg [`ADCRB_IRQ_W-1:0] irq_enable;
  reg [`ADCRB_IRQ_W-1:0] irq_flags;
  reg [15:0] result;

  // write channel capture
  reg aw_got;
  reg w_got;
  reg [5:0] aw_idx;
  reg [31:0] wd;
  reg [3:0] ws;
  // read channel
  reg [2:0] rd_state;
  reg [5:0] ar_idx;

  wire sync_pending;
  wire sync_done;
  wire soft_clear;
  wire [N-1:0] w_hit;
  wire [N-1:0] w_sel;
  wire [N*32-1:0] rw_q;
  wire en_lock;
  wire wr_needs_sync;
  wire wr_go;
  wire ctrl_wr;
  wire trig_wr;
  wire sync_start_wr;
  wire sync_start_rd;
  wire rd_is_synced;
  wire [`ADCRB_IRQ_W-1:0] irq_set;
  wire [`ADCRB_IRQ_W-1:0] irq_clr;
  reg [31:0] rd_mux;
  integer k;

  assign soft_clear = sync_done && soft_reset_bit;
  assign en_lock = ctrl_enable || adc_enabled;
  assign wr_needs_sync = (aw_idx == `ADCRB_IDX_CONTROL_PRIMARY)
    || (aw_idx == `ADCRB_IDX_SOFTWARE_TRIGGER) || |(w_hit & RW_WSYNC);
  // a synchronised write waits here while the handshake is busy
  assign wr_go = aw_got && w_got && !s_axi_bvalid && !(wr_needs_sync && sync_pending);
  assign ctrl_wr = wr_go && (aw_idx == `ADCRB_IDX_CONTROL_PRIMARY) && ws[0]
    && !peripheral_write_guard;
  assign trig_wr = wr_go && (aw_idx == `ADCRB_IDX_SOFTWARE_TRIGGER) && ws[0]
    && !peripheral_write_guard;
  assign sync_start_wr = ctrl_wr || trig_wr || |(w_sel & RW_WSYNC);
  assign rd_is_synced = (ar_idx == `ADCRB_IDX_SOFTWARE_TRIGGER)
    || (ar_idx == `ADCRB_IDX_INPUT_SELECT_CONTROL);
  // write starts have priority; a read only starts on an idle engine
  assign sync_start_rd = (rd_state == RD_WAIT) && !sync_pending && !sync_start_wr;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_rw
      assign w_hit[i] = (aw_idx == RW_IDX[i*6 +: 6]);
      assign w_sel[i] = wr_go && w_hit[i]
        && !(RW_WPROT[i] && peripheral_write_guard)
        && !(RW_EPROT[i] && en_lock);
      adcrb_field_reg #(
        .WMASK(RW_MASK[i*32 +: 32]),
        .SOFT_CLEARABLE(RW_SRST[i] ? 1 : 0)
      ) u_reg (
        .aclk(aclk),
        .aresetn(aresetn),
        .soft_clear(soft_clear),
        .wr_en(w_sel[i]),
        .wstrb(ws),
        .wdata(wd),
        .q(rw_q[i*32 +: 32])
      );
    end
  endgenerate

  adcrb_sync_engine u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(sync_start_wr || sync_start_rd),
    .busy(sync_pending),
    .done(sync_done)
  );

  // write address and data are taken independently, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_idx <= 6'h00;
      wd <= 32'h0000_0000;
      ws <= 4'h0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !aw_got && !s_axi_awready;
      s_axi_wready <= s_axi_wvalid && !w_got && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_idx <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wd <= s_axi_wdata;
        ws <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control_primary, software trigger and converter-side state
  always @(posedge aclk) begin
    if (!aresetn) begin
      soft_reset_bit <= 1'b0;
      ctrl_enable <= 1'b0;
      standby_run <= 1'b0;
      trig_start <= 1'b0;
      trig_flush <= 1'b0;
      adc_enabled <= 1'b0;
      adc_run <= 1'b0;
      sw_start <= 1'b0;
      sw_flush <= 1'b0;
    end else begin
      sw_start <= 1'b0;
      sw_flush <= 1'b0;
      if (ctrl_wr) begin
        // a zero in the reset bit never starts a reset
        if (wd[`ADCRB_BIT_SOFT_RESET]) begin
          // the other fields of this access are dropped
          soft_reset_bit <= 1'b1;
        end else begin
          ctrl_enable <= wd[`ADCRB_BIT_ENABLE];
          standby_run <= wd[`ADCRB_BIT_STANDBY_RUN];
        end
      end
      if (trig_wr) begin
        trig_start <= wd[`ADCRB_BIT_START];
        trig_flush <= wd[`ADCRB_BIT_FLUSH];
      end
      if (soft_clear) begin
        soft_reset_bit <= 1'b0;
        ctrl_enable <= 1'b0;
        standby_run <= 1'b0;
        trig_start <= 1'b0;
        trig_flush <= 1'b0;
        adc_enabled <= 1'b0;
      end else if (sync_done) begin
        adc_enabled <= ctrl_enable;
        sw_start <= trig_start;
        sw_flush <= trig_flush;
        trig_start <= 1'b0;
        trig_flush <= 1'b0;
      end
      // standby halts the converter unless standby_run keeps it going
      adc_run <= adc_enabled && (!standby_sleep || standby_run);
    end
  end

  assign irq_set = {sync_done, ev_winmon, ev_overrun, ev_resrdy};
  assign irq_clr = (wr_go && (aw_idx == `ADCRB_IDX_IRQ_FLAGS) && ws[0])
    ? wd[`ADCRB_IRQ_W-1:0] : {`ADCRB_IRQ_W{1'b0}};

  // flags, enables and the result word
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_flags <= {`ADCRB_IRQ_W{1'b0}};
      irq_enable <= {`ADCRB_IRQ_W{1'b0}};
      result <= 16'h0000;
    end else begin
      // a set arriving with the clear wins
      if (soft_clear) begin
        irq_flags <= irq_set;
      end else begin
        irq_flags <= (irq_flags & ~irq_clr) | irq_set;
      end
      if (soft_clear) begin
        irq_enable <= {`ADCRB_IRQ_W{1'b0}};
      end else if (wr_go && ws[0] && !peripheral_write_guard) begin
        if (aw_idx == `ADCRB_IDX_IRQ_ENABLE_CLEAR) begin
          irq_enable <= irq_enable & ~wd[`ADCRB_IRQ_W-1:0];
        end else if (aw_idx == `ADCRB_IDX_IRQ_ENABLE_SET) begin
          irq_enable <= irq_enable | wd[`ADCRB_IRQ_W-1:0];
        end
      end
      if (soft_clear) begin
        result <= 16'h0000;
      end else if (ev_resrdy) begin
        result <= conv_result;
      end
    end
  end

  // read data selection; anything unmapped stays zero
  always @* begin
    rd_mux = 32'h0000_0000;
    for (k = 0; k < N; k = k + 1) begin
      if (ar_idx == RW_IDX[k*6 +: 6]) begin
        rd_mux = rw_q[k*32 +: 32];
      end
    end
    case (ar_idx)
      `ADCRB_IDX_CONTROL_PRIMARY: begin
        rd_mux = {29'h0000_0000, standby_run, ctrl_enable, soft_reset_bit};
      end
      `ADCRB_IDX_SOFTWARE_TRIGGER: begin
        rd_mux = {30'h0000_0000, trig_start, trig_flush};
      end
      `ADCRB_IDX_IRQ_ENABLE_CLEAR, `ADCRB_IDX_IRQ_ENABLE_SET: begin
        rd_mux = {28'h000_0000, irq_enable};
      end
      `ADCRB_IDX_IRQ_FLAGS: begin
        rd_mux = {28'h000_0000, irq_flags};
      end
      `ADCRB_IDX_SYNC_STATUS: begin
        rd_mux = {24'h00_0000, sync_pending, 7'h00};
      end
      `ADCRB_IDX_CONVERSION_RESULT: begin
        rd_mux = {16'h0000, result};
      end
      default: begin
        rd_mux = rd_mux;
      end
    endcase
  end

  // read channel; software_trigger and input select reads pass through the handshake first
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
      ar_idx <= 6'h00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      case (rd_state)
        RD_IDLE: begin
          if (s_axi_arvalid && s_axi_arready) begin
            ar_idx <= s_axi_araddr[7:2];
            if ((s_axi_araddr[7:2] == `ADCRB_IDX_SOFTWARE_TRIGGER)
                || (s_axi_araddr[7:2] == `ADCRB_IDX_INPUT_SELECT_CONTROL)) begin
              rd_state <= RD_WAIT;
            end else begin
              rd_state <= RD_DATA;
            end
          end else if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
          end
        end
        RD_WAIT: begin
          if (sync_start_rd) begin
            rd_state <= RD_SYNC;
          end
        end
        RD_SYNC: begin
          if (sync_done) begin
            rd_state <= RD_DATA;
          end
        end
        RD_DATA: begin
          s_axi_rvalid <= 1'b1;
          s_axi_rdata <= rd_mux;
          s_axi_rresp <= RESP_OKAY;
          rd_state <= RD_HOLD;
        end
        RD_HOLD: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state <= RD_IDLE;
          end
        end
        default: begin
          rd_state <= RD_IDLE;
        end
      endcase
    end
  end
endmodule // adcrb_top

//--- tb/adcrb_checker.sv
// port-level assertions for the converter register bank
`timescale 1ns/100ps
module adcrb_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic standby_sleep,
  input wire logic adc_enabled,
  input wire logic adc_run,
  input wire logic sw_start
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since the last accepted write address; saturates so stale writes never alias
  logic [5:0] since_wr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_wr <= 6'h3f;
    end else if (s_axi_awvalid && s_axi_awready) begin
      since_wr <= 6'h00;
    end else if (since_wr != 6'h3f) begin
      since_wr <= since_wr + 6'h01;
    end
  end

  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  AST_WRITE_ANSWER: assert property (aw_taken |-> ##[1:40] s_axi_bvalid)
    else $error("write response missing");
  AST_READ_ANSWER: assert property (ar_taken |-> ##[1:40] s_axi_rvalid)
    else $error("read response missing");
  AST_BRESP_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
  AST_RRESP_OKAY: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00)
    else $error("read response not okay");
  AST_BVALID_CAUSE: assert property ($rose(s_axi_bvalid) |-> since_wr <= 6'd40)
    else $error("write response without write");
  AST_RUN_ENABLED: assert property (adc_run |-> $past(adc_enabled))
    else $error("converter runs while disabled");
  AST_RUN_AWAKE: assert property ($past(adc_enabled && !standby_sleep) |-> adc_run)
    else $error("converter halted while awake");
  AST_ENABLE_AFTER_WRITE: assert property ($changed(adc_enabled) |-> since_wr <= 6'd40)
    else $error("enable changed without a write");
  AST_START_AFTER_WRITE: assert property (sw_start |-> since_wr <= 6'd40)
    else $error("start pulse without a write");
  AST_START_PULSE: assert property (sw_start |=> !sw_start)
    else $error("start pulse longer than one cycle");
endmodule // adcrb_checker

bind adcrb_top adcrb_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rresp, .standby_sleep, .adc_enabled, .adc_run, .sw_start);

//--- tb/adcrb_tb_top.sv
// self-checking bench for the converter register bank over AXI4-Lite
`timescale 1ns/100ps
`include "adcrb_map.vh"
module adcrb_tb_top;
  localparam [5:0] ctl = `ADCRB_IDX_CONTROL_PRIMARY;
  localparam [5:0] rfc = `ADCRB_IDX_REFERENCE_CONTROL;
  localparam [5:0] ctb = `ADCRB_IDX_CONTROL_SECONDARY;
  localparam [5:0] win = `ADCRB_IDX_WINDOW_CONTROL;
  localparam [5:0] swt = `ADCRB_IDX_SOFTWARE_TRIGGER;
  localparam [5:0] isel = `ADCRB_IDX_INPUT_SELECT_CONTROL;
  localparam [5:0] irq = `ADCRB_IDX_IRQ_FLAGS;
  localparam [5:0] stat = `ADCRB_IDX_SYNC_STATUS;
  localparam [5:0] res = `ADCRB_IDX_CONVERSION_RESULT;
  localparam [5:0] dbg = `ADCRB_IDX_DEBUG_HOLD_CONTROL;
  localparam [5:0] ien_c = `ADCRB_IDX_IRQ_ENABLE_CLEAR;
  localparam [5:0] ien_s = `ADCRB_IDX_IRQ_ENABLE_SET;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // ready lines stay high: a response is taken the cycle it appears
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic peripheral_write_guard = 1'b0, standby_sleep = 1'b0;
  logic ev_resrdy = 1'b0, ev_overrun = 1'b0, ev_winmon = 1'b0;
  logic [15:0] conv_result = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic adc_enabled, adc_run, sw_start, sw_flush;
  int err_total = 0, checks = 0, cyc = 0, starts = 0, flushes = 0;

  always #2.5 aclk = ~aclk;

  adcrb_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .peripheral_write_guard,
    .standby_sleep, .conv_result, .ev_resrdy, .ev_overrun, .ev_winmon, .adc_enabled,
    .adc_run, .sw_start, .sw_flush);

  task automatic chk(input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input [5:0] i, input [31:0] d, input [3:0] s);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
  endtask

  task automatic rc(input [5:0] i, input [31:0] exp);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, exp);
  endtask

  // polls sync_status until the handshake has finished; the run timeout bounds it
  task automatic wait_sync;
    do begin
      s_axi_araddr <= {stat, 2'b00};
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
    end while (s_axi_rdata !== 32'h0000_0000);
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    starts += (sw_start === 1'b1);
    flushes += (sw_flush === 1'b1);
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      complete_run;
    end
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(ctl, 32'h0000_0000);
    wr(rfc, 32'hffff_ffff, 4'hf);
    rc(rfc, 32'h0000_008f);
    wr(6'h0b, 32'hffff_ffff, 4'hf);
    rc(6'h0b, 32'h0000_0000);
    $display("test unused bits done");
    wr(isel, 32'hffff_ffff, 4'b0100);
    rc(isel, 32'h00ff_0000);
    wr(isel, 32'hffff_0a05, 4'b0011);
    rc(isel, 32'h00ff_0a05);
    wr(isel, 32'h0123_0405, 4'hf);
    rc(isel, 32'h0123_0405);
    wr(ctb, 32'h0000_ffff, 4'b0010);
    rc(ctb, 32'h0000_0700);
    $display("test byte lanes done");
    peripheral_write_guard <= 1'b1;
    wr(rfc, 32'h0000_0000, 4'hf);
    rc(rfc, 32'h0000_008f);
    peripheral_write_guard <= 1'b0;
    $display("test write guard done");
    // the status read follows the enable write at once, so its busy bit is the enable's
    wr(ctl, 32'h0000_0002, 4'h1);
    rc(stat, 32'h0000_0080);
    wr(win, 32'h0000_0005, 4'h1);
    rc(ctl, 32'h0000_0002);
    rc(stat, 32'h0000_0080);
    rc(win, 32'h0000_0005);
    wait_sync;
    chk(adc_enabled, 32'h0000_0001);
    wr(rfc, 32'h0000_0000, 4'hf);
    rc(rfc, 32'h0000_008f);
    $display("test enable done");
    standby_sleep <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(adc_run, 32'h0000_0000);
    wr(ctl, 32'h0000_0006, 4'h1);
    rc(ctl, 32'h0000_0006);
    wait_sync;
    chk(adc_run, 32'h0000_0001);
    standby_sleep <= 1'b0;
    $display("test standby done");
    wr(irq, 32'h0000_000f, 4'h1);
    conv_result <= 16'habcd;
    ev_resrdy <= 1'b1;
    ev_overrun <= 1'b1;
    ev_winmon <= 1'b1;
    @(posedge aclk);
    ev_resrdy <= 1'b0;
    ev_overrun <= 1'b0;
    ev_winmon <= 1'b0;
    rc(res, 32'h0000_abcd);
    rc(irq, 32'h0000_0007);
    wr(irq, 32'h0000_0001, 4'h1);
    rc(irq, 32'h0000_0006);
    wr(irq, 32'h0000_0000, 4'h1);
    rc(irq, 32'h0000_0006);
    $display("test flags done");
    wr(swt, 32'h0000_0003, 4'h1);
    wait_sync;
    // one more edge so the pulse counters have seen the last pulse
    @(posedge aclk);
    chk(starts, 32'h0000_0001);
    chk(flushes, 32'h0000_0001);
    $display("test trigger done");
    wr(ien_s, 32'h0000_000f, 4'h1);
    wr(ien_c, 32'h0000_0005, 4'h1);
    rc(ien_s, 32'h0000_000a);
    rc(ien_c, 32'h0000_000a);
    $display("test irq enables done");
    wr(dbg, 32'h0000_0001, 4'h1);
    // enable stays set: the zero written beside the reset bit is dropped
    wr(ctl, 32'h0000_0005, 4'h1);
    rc(ctl, 32'h0000_0007);
    rc(stat, 32'h0000_0080);
    wait_sync;
    rc(ctl, 32'h0000_0000);
    rc(rfc, 32'h0000_0000);
    rc(dbg, 32'h0000_0001);
    rc(ien_s, 32'h0000_0000);
    chk(adc_enabled, 32'h0000_0000);
    $display("test soft reset done");
    complete_run;
  end
endmodule // adcrb_tb_top
